// ==== bench/aoms_fe_model.sv ====
`timescale 1ns/100ps
`include "aoms_consts.vh"
module aoms_fe_model (
  input wire ref_clk, // Clock.
  input wire rstn, // Reset, active low.
  input wire [1:0] tick_gap, // Idle cycles between ticks.
  output reg conv_tick, // End of one conversion cycle.
  output reg [`AOMS_DATA_W-1:0] pri_sample, // Primary sample.
  output reg [`AOMS_DATA_W-1:0] aux_sample // Auxiliary sample.
);
  reg [1:0] wait_q;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      conv_tick <= 1'h0;
      wait_q <= 2'h0;
      pri_sample <= 24'h0;
      aux_sample <= 24'h0;
    end else if (wait_q >= tick_gap) begin
      conv_tick <= 1'h1;
      wait_q <= 2'h0;
      pri_sample <= $urandom;
      aux_sample <= $urandom;
    end else begin
      conv_tick <= 1'h0;
      wait_q <= wait_q + 2'h1;
      // Samples mean nothing between ticks, so they keep moving.
      pri_sample <= ~pri_sample;
      aux_sample <= ~aux_sample;
    end
  end
endmodule // aoms_fe_model

// ==== bench/aoms_seq_assertions.sv ====
`timescale 1ns/100ps
`include "aoms_consts.vh"
module aoms_seq_assertions (
  input wire ref_clk, // Clock.
  input wire rstn, // Reset, active low.
  input wire mode_wr, // Mode write.
  input wire [2:0] mode_wr_data, // Mode code.
  input wire pri_en, // Primary enable.
  input wire pri_rdy_clr, // Primary ready clear.
  input wire [2:0] operation_mode_field_q, // Mode.
  input wire conv_pwr_down, // Power down.
  input wire conv_hold_rst, // Held in reset.
  input wire [1:0] afe_src_sel, // Input source.
  input wire busy, // Busy.
  input wire cal_done_q, // Calibration done.
  input wire [23:0] primary_result_reg, // Primary result.
  input wire pri_result_ready_flag, // Primary ready.
  input wire [23:0] pri_offset_coefficient_reg, // Offset coefficient.
  input wire [23:0] pri_gain_coefficient_reg // Gain coefficient.
);
  wire [2:0] md = operation_mode_field_q;
  wire [23:0] res = primary_result_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_pwrdn_stop: assert property (mode_wr && mode_wr_data == 3'h0 |=> conv_pwr_down && conv_hold_rst && !busy)
    else $error("power-down mode not entered");
  a_cont_stays: assert property (md == 3'h1 && !mode_wr |=> md == 3'h1)
    else $error("continuous mode left");
  a_cont_hold: assert property (md == 3'h1 && pri_result_ready_flag && !pri_rdy_clr |=> $stable(res))
    else $error("result overwritten while ready");
  a_single_idle: assert property (md == 3'h2 && !mode_wr |=> md == 3'h2 || md == 3'h3)
    else $error("single conversion ended wrongly");
  a_idle_hold: assert property (md == 3'h3 |-> conv_hold_rst && !conv_pwr_down && !busy)
    else $error("idle mode outputs wrong");
  a_cal_idle: assert property (md[2] && !mode_wr |=> md == $past(md) || md == 3'h3)
    else $error("calibration did not return to idle");
  a_off_zero: assert property (md == 3'h4 |-> afe_src_sel == 2'h1)
    else $error("offset calibration source wrong");
  a_off_store: assert property ((md == 3'h4 || md == 3'h6) && !mode_wr && pri_en ##1 md == 3'h3 |->
    pri_offset_coefficient_reg == res && pri_result_ready_flag && cal_done_q)
    else $error("offset calibration end wrong");
  a_gain_store: assert property ((md == 3'h5 || md == 3'h7) && !mode_wr && pri_en ##1 md == 3'h3 |->
    pri_gain_coefficient_reg == res && pri_result_ready_flag && cal_done_q)
    else $error("gain calibration end wrong");
  a_sys_pins: assert property (md[2:1] == 2'h3 |-> afe_src_sel == 2'h0)
    else $error("system calibration source wrong");
  a_restart: assert property (mode_wr |=> md == $past(mode_wr_data))
    else $error("mode write not taken");
endmodule // aoms_seq_assertions
bind aoms_seq aoms_seq_assertions chk_u (.*);

// ==== bench/aoms_seq_bench.sv ====
`timescale 1ns/100ps
`include "aoms_consts.vh"
module aoms_seq_bench;
  reg ref_clk = 0, rstn = 0, mode_wr = 0, pri_en = 1, aux_en = 1, chop_en = 0;
  reg pri_rdy_clr = 0, aux_rdy_clr = 0, cal_done_clr = 0;
  reg [2:0] mode_wr_data = 3'h3;
  reg [1:0] tick_gap = 2'h1;
  wire conv_tick, conv_pwr_down, conv_hold_rst, busy, cal_done_q, pri_result_ready_flag, aux_result_ready_flag;
  wire [2:0] operation_mode_field_q;
  wire [1:0] afe_src_sel;
  wire [23:0] primary_result_reg, auxiliary_result_reg, pri_offset_coefficient_reg, aux_offset_coefficient_reg;
  wire [23:0] pri_gain_coefficient_reg, aux_gain_coefficient_reg, pri_sample, aux_sample;
  integer n_fail = 0, n_checks = 0, i, m, cnt, n, tot, done, sx, k, seed;
  reg [23:0] res [0:1], off [0:1], gn [0:1];
  reg rdy [0:1], cd;
  aoms_seq dut_u (.*);
  aoms_fe_model fe_u (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task check(input [127:0] g, input [127:0] x);
    n_checks = n_checks + 1;
    if (g !== x) begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task lane(input integer k, input en, input clr, input [23:0] s);
    if (!en) rdy[k] = 0;
    else if (done && (m != 1 || !rdy[k] || clr)) begin
      res[k] = s;
      rdy[k] = 1;
      if (m == 4 || m == 6) off[k] = s;
      if (m == 5 || m == 7) gn[k] = s;
    end else if (clr) rdy[k] = 0;
  endtask
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      m = 3; cnt = 0; cd = 0;
      for (i = 0; i < 2; i = i + 1) begin
        rdy[i] = 0; res[i] = 0; off[i] = 0; gn[i] = 24'h400000;
      end
    end else begin
      n = chop_en ? 3 : 2;
      tot = (m == 5) ? 2 * n : n;
      done = 0;
      if (!mode_wr && m != 0 && m != 3 && conv_tick) begin
        cnt = cnt + 1;
        done = cnt >= tot;
        if (cnt > tot) cnt = tot;
      end
      lane(0, pri_en, pri_rdy_clr, pri_sample);
      lane(1, aux_en, aux_rdy_clr, aux_sample);
      if (done && m >= 4) cd = 1;
      else if (cal_done_clr) cd = 0;
      if (done && m != 1) begin m = 3; cnt = 0; end
      if (mode_wr) begin m = mode_wr_data; cnt = 0; end
    end
  end
  always @(negedge ref_clk) begin
    if (rstn) begin
      sx = chop_en ? 3 : 2;
      check({operation_mode_field_q, conv_pwr_down, conv_hold_rst, busy},
            {m[2:0], m == 0, m == 0 || m == 3, m != 0 && m != 3});
      check(afe_src_sel, (m == 4 || (m == 5 && cnt < sx)) ? 2'h1 : (m == 5) ? 2'h2 : 2'h0);
      check({pri_result_ready_flag, aux_result_ready_flag, cal_done_q}, {rdy[0], rdy[1], cd});
      check({primary_result_reg, auxiliary_result_reg}, {res[0], res[1]});
      check({pri_offset_coefficient_reg, aux_offset_coefficient_reg, pri_gain_coefficient_reg, aux_gain_coefficient_reg},
            {off[0], off[1], gn[0], gn[1]});
    end
  end
  task wr(input [2:0] c, input integer w);
    @(posedge ref_clk);
    pri_en <= ($urandom % 8) != 0;
    tick_gap <= $urandom;
    @(posedge ref_clk);
    mode_wr <= 1;
    mode_wr_data <= c;
    @(posedge ref_clk);
    mode_wr <= 0;
    // Chop and the auxiliary enable change only where a new operation starts.
    chop_en <= $urandom;
    aux_en <= (c == 3'h5) ? 1'b0 : $urandom;
    repeat (w) begin
      @(posedge ref_clk);
      pri_rdy_clr <= ($urandom % 4) == 0;
      aux_rdy_clr <= ($urandom % 4) == 0;
      cal_done_clr <= ($urandom % 8) == 0;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    summarize;
  end
  initial begin
    seed = $urandom(32'h67dd);
    repeat (8) @(posedge ref_clk);
    rstn <= 1;
    for (k = 0; k < 16; k = k + 1) wr(k[2:0], 40);
    repeat (300) wr($urandom, $urandom % 14);
    @(posedge ref_clk);
    mode_wr <= 1;
    mode_wr_data <= 3'h5;
    @(posedge ref_clk);
    mode_wr_data <= 3'h4;
    wr(3'h1, 6);
    rstn <= 0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1;
    wr(3'h5, 30);
    summarize;
  end
endmodule // aoms_seq_bench

// ==== core/aoms_conv_lane.v ====
`timescale 1ns/100ps
`include "aoms_consts.vh"

// Result, ready flag and calibration coefficients of one converter.
module aoms_conv_lane (
  input wire ref_clk, // System clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire lane_en, // Converter enabled.
  input wire res_wr, // Pulse: a new result is offered.
  input wire [`AOMS_DATA_W-1:0] res_data, // Offered result.
  input wire hold_if_ready, // Refuse new results while ready is set.
  input wire rdy_clr, // Pulse: software clears the ready flag.
  input wire off_wr, // Pulse: store offset coefficient.
  input wire gain_wr, // Pulse: store gain coefficient.
  output reg [`AOMS_DATA_W-1:0] result_q, // Result register.
  output reg rdy_q, // Result ready flag.
  output reg [`AOMS_DATA_W-1:0] off_coef_q, // Offset coefficient register.
  output reg [`AOMS_DATA_W-1:0] gain_coef_q // Gain coefficient register.
);

  wire blocked;
  wire take;
  reg rdy_d;

  // A clear in the same cycle unblocks the lane so that the new result is taken.
  assign blocked = hold_if_ready & rdy_q & ~rdy_clr;
  assign take = lane_en & res_wr & ~blocked;

  always @* begin
    rdy_d = rdy_q;
    if (!lane_en) begin
      rdy_d = 1'b0;
    end else if (take) begin
      rdy_d = 1'b1;
    end else if (rdy_clr) begin
      rdy_d = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_q <= `AOMS_RESULT_RST;
      rdy_q <= 1'b0;
      off_coef_q <= `AOMS_OFF_COEF_RST;
      gain_coef_q <= `AOMS_GAIN_COEF_RST;
    end else begin
      rdy_q <= rdy_d;
      if (take) begin
        result_q <= res_data;
      end
      if (lane_en && off_wr) begin
        off_coef_q <= res_data;
      end
      if (lane_en && gain_wr) begin
        gain_coef_q <= res_data;
      end
    end
  end

endmodule // aoms_conv_lane

// ==== core/aoms_seq.v ====
`timescale 1ns/100ps
`include "aoms_consts.vh"

// What this block does
// - Mode 000 powers down all converter circuits and the amplifier; no conversions.
// - Mode 001 converts every enabled converter once per output period, until changed.
// - Continuous mode keeps a result until its ready flag is cleared by software.
// - Mode 010 converts each enabled converter once, then enters idle automatically.
// - A single conversion takes two cycles, or three with chopping.
// - Mode 011 keeps converters powered but held in reset.
// - Every calibration ends with an automatic return to idle.
// - Mode 100 calibrates offset against internal zero with current settings.
// - Offset calibration takes the same two or three cycles as a conversion.
// - Offset calibration result lands in the calibrated converter's offset coefficient.
// - Offset calibration end: idle, calibration-done and result-ready flags set.
// - Mode 101 runs a two-stage gain calibration, twice the offset duration.
// - Self-gain calibration result lands in the converter's gain coefficient.
// - Gain calibration end: idle, calibration-done and result-ready flags set.
// - Mode 110 runs zero-scale calibration from the pins, shorted externally.
// - Mode 111 runs full-scale calibration from the pins, updating gain coefficient.
module aoms_seq (
  input wire ref_clk, // System clock, 100 MHz.
  input wire rstn, // Asynchronous reset, active low.
  input wire mode_wr, // Pulse: write the mode field.
  input wire [`AOMS_MODE_W-1:0] mode_wr_data, // New mode code.
  input wire pri_en, // Primary converter enabled.
  input wire aux_en, // Auxiliary converter enabled.
  input wire chop_en, // Chopping active.
  input wire conv_tick, // Pulse: one conversion cycle of the front end has ended.
  input wire [`AOMS_DATA_W-1:0] pri_sample, // Primary front-end sample.
  input wire [`AOMS_DATA_W-1:0] aux_sample, // Auxiliary front-end sample.
  input wire pri_rdy_clr, // Pulse: clear primary ready flag.
  input wire aux_rdy_clr, // Pulse: clear auxiliary ready flag.
  input wire cal_done_clr, // Pulse: clear calibration-done flag.
  output reg [`AOMS_MODE_W-1:0] operation_mode_field_q, // Mode field readback.
  output wire conv_pwr_down, // Converters and amplifier powered down.
  output wire conv_hold_rst, // Converters held in reset.
  output wire [1:0] afe_src_sel, // Front-end input source.
  output wire busy, // Conversion or calibration in progress.
  output reg cal_done_q, // Calibration-done flag.
  output wire [`AOMS_DATA_W-1:0] primary_result_reg, // Primary result.
  output wire [`AOMS_DATA_W-1:0] auxiliary_result_reg, // Auxiliary result.
  output wire pri_result_ready_flag, // Primary result ready.
  output wire aux_result_ready_flag, // Auxiliary result ready.
  output wire [`AOMS_DATA_W-1:0] pri_offset_coefficient_reg, // Primary offset coefficient.
  output wire [`AOMS_DATA_W-1:0] aux_offset_coefficient_reg, // Auxiliary offset coefficient.
  output wire [`AOMS_DATA_W-1:0] pri_gain_coefficient_reg, // Primary gain coefficient.
  output wire [`AOMS_DATA_W-1:0] aux_gain_coefficient_reg // Auxiliary gain coefficient.
);

  localparam ST_STOP = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_STREAM = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg stage_q;
  reg stage_d;
  reg [`AOMS_MODE_W-1:0] mode_d;
  reg cal_done_d;
  reg op_done;

  wire [1:0] settle_cycles;
  wire is_cont;
  wire is_off_cal;
  wire is_gain_cal;
  wire is_cal;
  wire res_wr;
  wire off_wr;
  wire gain_wr;
  wire stopped_mode;

  // Settling length of one conversion, also used by every calibration stage.
  assign settle_cycles = chop_en ? `AOMS_SETTLE_CHOP : `AOMS_SETTLE_PLAIN;

  assign is_cont = (operation_mode_field_q == `AOMS_MODE_CONT);
  assign is_off_cal = (operation_mode_field_q == `AOMS_MODE_SELF_OFF) ||
                      (operation_mode_field_q == `AOMS_MODE_SYS_ZERO);
  assign is_gain_cal = (operation_mode_field_q == `AOMS_MODE_SELF_GAIN) ||
                       (operation_mode_field_q == `AOMS_MODE_SYS_FULL);
  assign is_cal = is_off_cal | is_gain_cal;

  assign stopped_mode = (mode_wr_data == `AOMS_MODE_PWRDN) || (mode_wr_data == `AOMS_MODE_IDLE);

  assign conv_pwr_down = (operation_mode_field_q == `AOMS_MODE_PWRDN);
  // Idle keeps power on but holds the modulators in reset.
  assign conv_hold_rst = conv_pwr_down || (operation_mode_field_q == `AOMS_MODE_IDLE);
  assign busy = (state_q != ST_STOP);

  // Self calibrations switch the front end to internal sources, system ones use the pins.
  assign afe_src_sel = (operation_mode_field_q == `AOMS_MODE_SELF_OFF) ? `AOMS_SRC_ZERO :
                       (operation_mode_field_q == `AOMS_MODE_SELF_GAIN) ?
                       (stage_q ? `AOMS_SRC_REF : `AOMS_SRC_ZERO) :
                       `AOMS_SRC_PINS;

  // Sequencer: counts conversion cycles and decides the end of each operation.
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    stage_d = stage_q;
    mode_d = operation_mode_field_q;
    op_done = 1'b0;
    case (state_q)
      ST_STOP: begin
        cnt_d = 2'h0;
        stage_d = 1'b0;
      end
      ST_RUN: begin
        if (conv_tick) begin
          // A chop change mid-run shortens the count instead of letting it wrap.
          if (cnt_q >= settle_cycles - 2'h1) begin
            cnt_d = 2'h0;
            if ((operation_mode_field_q == `AOMS_MODE_SELF_GAIN) && !stage_q) begin
              stage_d = 1'b1;
            end else begin
              op_done = 1'b1;
              if (is_cont) begin
                state_d = ST_STREAM;
              end else begin
                state_d = ST_STOP;
                mode_d = `AOMS_MODE_IDLE;
              end
            end
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      ST_STREAM: begin
        cnt_d = 2'h0;
      end
      default: begin
        state_d = ST_STOP;
        cnt_d = 2'h0;
        stage_d = 1'b0;
      end
    endcase
    // A new mode overrides completion and restarts from the first cycle.
    if (mode_wr) begin
      mode_d = mode_wr_data;
      cnt_d = 2'h0;
      stage_d = 1'b0;
      state_d = stopped_mode ? ST_STOP : ST_RUN;
    end
  end

  // Continuous mode offers a result every conversion cycle once settled.
  assign res_wr = ~mode_wr & (op_done | ((state_q == ST_STREAM) & conv_tick));
  assign off_wr = ~mode_wr & op_done & is_off_cal;
  assign gain_wr = ~mode_wr & op_done & is_gain_cal;

  always @* begin
    cal_done_d = cal_done_q;
    if (op_done && is_cal && !mode_wr) begin
      cal_done_d = 1'b1;
    end else if (cal_done_clr) begin
      cal_done_d = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_STOP;
      cnt_q <= 2'h0;
      stage_q <= 1'b0;
      operation_mode_field_q <= `AOMS_MODE_RST;
      cal_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      stage_q <= stage_d;
      operation_mode_field_q <= mode_d;
      cal_done_q <= cal_done_d;
    end
  end

  aoms_conv_lane u_pri_lane (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .lane_en(pri_en),
    .res_wr(res_wr),
    .res_data(pri_sample),
    .hold_if_ready(is_cont),
    .rdy_clr(pri_rdy_clr),
    .off_wr(off_wr),
    .gain_wr(gain_wr),
    .result_q(primary_result_reg),
    .rdy_q(pri_result_ready_flag),
    .off_coef_q(pri_offset_coefficient_reg),
    .gain_coef_q(pri_gain_coefficient_reg)
  );

  aoms_conv_lane u_aux_lane (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .lane_en(aux_en),
    .res_wr(res_wr),
    .res_data(aux_sample),
    .hold_if_ready(is_cont),
    .rdy_clr(aux_rdy_clr),
    .off_wr(off_wr),
    .gain_wr(gain_wr),
    .result_q(auxiliary_result_reg),
    .rdy_q(aux_result_ready_flag),
    .off_coef_q(aux_offset_coefficient_reg),
    .gain_coef_q(aux_gain_coefficient_reg)
  );

endmodule // aoms_seq

// ==== inc/aoms_consts.vh ====
`ifndef AOMS_CONSTS_VH
`define AOMS_CONSTS_VH

// Operation mode codes of the 3-bit mode field.
`define AOMS_MODE_W 3
`define AOMS_MODE_PWRDN 3'h0
`define AOMS_MODE_CONT 3'h1
`define AOMS_MODE_SINGLE 3'h2
`define AOMS_MODE_IDLE 3'h3
`define AOMS_MODE_SELF_OFF 3'h4
`define AOMS_MODE_SELF_GAIN 3'h5
`define AOMS_MODE_SYS_ZERO 3'h6
`define AOMS_MODE_SYS_FULL 3'h7
`define AOMS_MODE_RST 3'h3

// Result and coefficient layout.
`define AOMS_DATA_W 24
`define AOMS_RESULT_RST 24'h000000
`define AOMS_OFF_COEF_RST 24'h000000
`define AOMS_GAIN_COEF_RST 24'h400000

// Conversion cycles needed before a settled result, without and with chopping.
`define AOMS_SETTLE_PLAIN 2'h2
`define AOMS_SETTLE_CHOP 2'h3

// Front-end input source selection.
`define AOMS_SRC_PINS 2'h0
`define AOMS_SRC_ZERO 2'h1
`define AOMS_SRC_REF 2'h2

`endif
